// File: lcdhi_pkg.sv
// Shared constants and types of the LCD host port pair
package lcdhi_pkg;
  // ==========================================================
  // Link timing
  localparam int CLK_NS = 5;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 40;
  localparam int HOLD_NS = 20;
  localparam int PHASE_NS = 20;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================
  // Synchroniser vector layout of the device
  localparam int SV_W = 15;
  localparam int SV_BUS = 0;
  localparam int SV_WR = 8;
  localparam int SV_RD = 9;
  localparam int SV_DC = 10;
  localparam int SV_CS = 11;
  localparam int SV_STY = 12;
  localparam int SV_IF = 13;
  localparam int SV_RST = 14;
  localparam logic [SV_W-1:0] SV_RST_VAL = 15'h7f00;
  localparam int SER_CLK_BIT = 6;
  localparam int SER_DAT_BIT = 7;
  localparam logic [7:0] SER_OE = 8'hc0;
  localparam logic [7:0] PAR_OE = 8'hff;
  // ==========================================================
  // Receive buffer
  localparam int FIFO_DEPTH = 2;
  localparam int FIFO_W = 9;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  // ==========================================================
  // Controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RX = 8'h0c;
  localparam int CTRL_IF = 0;
  localparam int CTRL_STY = 1;
  localparam int CTRL_RST = 2;
  localparam logic [2:0] CTRL_RST_VAL = 3'h5;
  localparam int CMD_DC = 8;
  localparam int CMD_RD = 9;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_SLOW, H_SHIGH} lcdhi_hstate_t;
endpackage : lcdhi_pkg

// File: lcdhi_if.sv
// Pin-level link between the host controller and the LCD host port
`timescale 1ns/1ps
interface lcdhi_if;
  logic chip_reset_n;
  logic interface_select;
  logic bus_style_select;
  logic unit_select_n;
  logic data_command_select;
  logic rd_strobe_pin;
  logic wr_strobe_pin;
  logic [7:0] host_dout;
  logic [7:0] host_doe;
  logic [7:0] dev_dout;
  logic [7:0] dev_doe;
  logic [7:0] host_data_bus;
  // Undriven bits read high, as with a weak pull-up
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bus
      assign host_data_bus[g] = host_doe[g] ? host_dout[g] : (dev_doe[g] ? dev_dout[g] : 1'b1);
    end
  endgenerate
  modport host (
    output chip_reset_n, interface_select, bus_style_select, unit_select_n,
    output data_command_select, rd_strobe_pin, wr_strobe_pin, host_dout, host_doe,
    input host_data_bus
  );
  modport device (
    input chip_reset_n, interface_select, bus_style_select, unit_select_n,
    input data_command_select, rd_strobe_pin, wr_strobe_pin, host_data_bus,
    output dev_dout, dev_doe
  );
endinterface : lcdhi_if

// File: lcdhi_device.sv
// Device end of the LCD host port: parallel and serial receive, parallel read drive
// How it works
// - Interface select high: 8-bit two-way bus
// - Serial: data on bit 7, bits 0-5 floating
// - Serial: bit 6 is shift clock
// - Select high floats all eight data pins
// - Data/command line tags each transfer
// - Style select high 68, low 80
// - 80 style: drive bus only while read low
// - 80 style: latch on write strobe rise
// - 68 style: enable strobe qualifies each cycle
// - 68 style: direction line sets bus direction
// - Parallel mode ignores the serial clock
// - Serial: no reads, strobes held fixed
`timescale 1ns/1ps
module lcdhi_device (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  lcdhi_if.device link,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_is_data,
  output logic rx_overflow,
  input wire logic [7:0] rd_status,
  input wire logic [7:0] rd_display,
  output logic rd_taken,
  output logic serial_mode,
  output logic style68,
  output logic [lcdhi_pkg::FIFO_W-8:0] rx_count
);
  import lcdhi_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [SV_W-1:0] s1_r;
  logic [SV_W-1:0] s2_r;
  logic [SV_W-1:0] s3_r;

  // Data is synchronised with the strobes so that the byte seen
  // one stage back belongs to the strobe level before the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= SV_RST_VAL;
      s2_r <= SV_RST_VAL;
      s3_r <= SV_RST_VAL;
    end else if (ce) begin
      s1_r <= {link.chip_reset_n, link.interface_select, link.bus_style_select,
               link.unit_select_n, link.data_command_select, link.rd_strobe_pin,
               link.wr_strobe_pin, link.host_data_bus};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ==========================================================
  // Decoded pin levels and edges
  logic run;
  logic par;
  logic cs_act;
  logic dc;
  logic rdp;
  logic rdp_q;
  logic wrp;
  logic wrp_q;
  logic read_act;
  logic wr_done;
  logic rd_done;
  logic ser_edge;

  assign run = s2_r[SV_RST] & s3_r[SV_RST];
  assign par = s2_r[SV_IF];
  assign style68 = s2_r[SV_STY];
  assign serial_mode = ~par;
  assign cs_act = ~s2_r[SV_CS];
  assign dc = s2_r[SV_DC];
  assign rdp = s2_r[SV_RD];
  assign rdp_q = s3_r[SV_RD];
  assign wrp = s2_r[SV_WR];
  assign wrp_q = s3_r[SV_WR];

  // Strobe pins only count in parallel mode
  assign read_act = par & cs_act & (style68 ? (rdp & wrp) : ~rdp);

  assign wr_done = run & par & cs_act &
                   (style68 ? (rdp_q & ~rdp & ~wrp_q)
                            : (~wrp_q & wrp));

  assign rd_done = run & par & cs_act &
                   (style68 ? (rdp_q & ~rdp & wrp_q)
                            : (~rdp_q & rdp));

  // Bit 6 acts as a clock only in serial mode
  assign ser_edge = run & ~par & cs_act &
                    ~s3_r[SV_BUS+SER_CLK_BIT] & s2_r[SV_BUS+SER_CLK_BIT];

  // ==========================================================
  // Serial shifter
  logic [6:0] sh_r;
  logic [2:0] bit_r;
  logic ser_last;

  assign ser_last = ser_edge & (bit_r == 3'h7);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_r <= 3'h0;
    end else if (ce) begin
      if (!run || !cs_act || par) begin
        bit_r <= 3'h0;
      end else if (ser_edge) begin
        bit_r <= bit_r + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= 7'h00;
    end else if (ce) begin
      if (!run) begin
        sh_r <= 7'h00;
      end else if (ser_edge) begin
        sh_r <= {sh_r[5:0], s2_r[SV_BUS+SER_DAT_BIT]};
      end
    end
  end

  // ==========================================================
  // Two-entry receive buffer
  logic [FIFO_W-1:0] mem_r [FIFO_DEPTH];
  logic wptr_r;
  logic rptr_r;
  logic [1:0] cnt_r;
  logic push_v;
  logic [FIFO_W-1:0] push_d;
  logic in_ready;
  logic push;
  logic pop;

  assign push_v = wr_done | ser_last;
  assign push_d = ser_last ? {dc, sh_r, s2_r[SV_BUS+SER_DAT_BIT]}
                           : {dc, s3_r[SV_BUS+7:SV_BUS]};
  assign in_ready = (cnt_r != FIFO_FULL);
  assign push = push_v & in_ready;
  assign pop = rx_valid & rx_ready;
  assign rx_valid = (cnt_r != 2'h0);
  assign rx_data = mem_r[rptr_r][7:0];
  assign rx_is_data = mem_r[rptr_r][8];
  assign rx_count = cnt_r;

  genvar g;
  generate
    for (g = 0; g < FIFO_DEPTH; g++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[g] <= 9'h000;
        end else if (ce && push && (wptr_r == 1'(g))) begin
          mem_r[g] <= push_d;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (ce) begin
      if (!run) begin
        wptr_r <= 1'b0;
        rptr_r <= 1'b0;
        cnt_r <= 2'h0;
      end else begin
        if (push) begin
          wptr_r <= ~wptr_r;
        end
        if (pop) begin
          rptr_r <= ~rptr_r;
        end
        cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  // The host has no busy pin to stall on, so a byte that
  // meets a full buffer is lost and flagged here instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overflow <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        rx_overflow <= 1'b0;
      end else if (push_v && !in_ready) begin
        rx_overflow <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read drive
  logic [7:0] dout_r;
  logic [7:0] doe_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r <= 8'h00;
    end else if (ce) begin
      dout_r <= dc ? rd_display : rd_status;
    end
  end

  // Serial mode and a high select never drive any pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doe_r <= 8'h00;
    end else if (ce) begin
      doe_r <= (run && read_act) ? PAR_OE : 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_taken <= 1'b0;
    end else if (ce) begin
      rd_taken <= rd_done;
    end
  end

  assign link.dev_dout = dout_r;
  assign link.dev_doe = doe_r;
endmodule : lcdhi_device

// File: lcdhi_host.sv
// Host end of the LCD host port: APB-controlled bus master for the link pins
`timescale 1ns/1ps
module lcdhi_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lcdhi_if.host link
);
  import lcdhi_pkg::*;

  // ==========================================================
  // Register slave
  logic [2:0] ctrl_r;
  logic [9:0] cmd_r;
  logic [7:0] rx_r;
  logic [31:0] prdata_r;
  lcdhi_hstate_t st_r;
  logic busy;
  logic mapped;
  logic wr_acc;
  logic start;
  logic par;
  logic st68;
  logic rd_op;

  assign busy = (st_r != H_IDLE);
  assign mapped = (paddr == REG_CTRL) | (paddr == REG_CMD) | (paddr == REG_STAT) | (paddr == REG_RX);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;
  assign wr_acc = psel & penable & pwrite & mapped;
  assign par = ctrl_r[CTRL_IF];
  assign st68 = ctrl_r[CTRL_STY];
  assign rd_op = cmd_r[CMD_RD];
  // No reads exist in serial mode, so such a command is dropped
  assign start = wr_acc & (paddr == REG_CMD) & ~busy & (par | ~pwdata[CMD_RD]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST_VAL;
    end else if (ce && wr_acc && (paddr == REG_CTRL) && !busy) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 10'h000;
    end else if (ce && start) begin
      cmd_r <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      unique case (paddr)
        REG_CTRL: prdata_r <= {29'h0000_0000, ctrl_r};
        REG_CMD: prdata_r <= {22'h00_0000, cmd_r};
        REG_STAT: prdata_r <= {31'h0000_0000, busy};
        REG_RX: prdata_r <= {24'h00_0000, rx_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Read-back synchroniser
  logic [7:0] b1_r;
  logic [7:0] b2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b1_r <= 8'h00;
      b2_r <= 8'h00;
    end else if (ce) begin
      b1_r <= link.host_data_bus;
      b2_r <= b1_r;
    end
  end

  // ==========================================================
  // Transfer sequencer
  logic [3:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [3:0] lim;
  logic tick;

  always_comb begin
    lim = PHASE_CYC;
    unique case (st_r)
      H_SETUP: lim = SETUP_CYC;
      H_STROBE: lim = STROBE_CYC;
      H_HOLD: lim = HOLD_CYC;
      H_IDLE, H_SLOW, H_SHIGH: lim = PHASE_CYC;
    endcase
  end
  assign tick = (cnt_r == lim - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= H_IDLE;
      cnt_r <= 4'h0;
    end else if (ce) begin
      cnt_r <= (st_r == H_IDLE || tick) ? 4'h0 : cnt_r + 4'h1;
      unique case (st_r)
        H_IDLE: if (start) st_r <= par ? H_SETUP : H_SLOW;
        H_SETUP: if (tick) st_r <= H_STROBE;
        H_STROBE: if (tick) st_r <= H_HOLD;
        H_SLOW: if (tick) st_r <= H_SHIGH;
        H_SHIGH: if (tick) st_r <= (bit_r == 3'h7) ? H_HOLD : H_SLOW;
        H_HOLD: if (tick) st_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_r <= 3'h0;
      sh_r <= 8'h00;
    end else if (ce) begin
      if (start) begin
        bit_r <= 3'h0;
        sh_r <= pwdata[7:0];
      end else if (st_r == H_SHIGH && tick) begin
        bit_r <= bit_r + 3'h1;
        sh_r <= {sh_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_r <= 8'h00;
    end else if (ce && st_r == H_STROBE && tick && rd_op) begin
      rx_r <= b2_r;
    end
  end

  // ==========================================================
  // Pin drive, registered to keep the pins free of decode glitches
  logic cs_n_r;
  logic dc_r;
  logic rdp_r;
  logic wrp_r;
  logic [7:0] dout_r;
  logic [7:0] doe_r;
  logic if_r;
  logic sty_r;
  logic strobe;

  assign strobe = (st_r == H_STROBE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n_r <= 1'b1;
      dc_r <= 1'b0;
      rdp_r <= 1'b1;
      wrp_r <= 1'b1;
      dout_r <= 8'h00;
      doe_r <= 8'h00;
      if_r <= CTRL_RST_VAL[CTRL_IF];
      sty_r <= CTRL_RST_VAL[CTRL_STY];
    end else if (ce) begin
      // Mode pins share the strobes' register stage, so a mode switch and the
      // strobe levels of the new mode reach the pins at one edge
      if_r <= par;
      sty_r <= st68;
      cs_n_r <= ~busy;
      dc_r <= cmd_r[CMD_DC];
      if (!par) begin
        rdp_r <= 1'b1;
        wrp_r <= 1'b1;
        dout_r <= {sh_r[7], (st_r == H_SHIGH), 6'h00};
        doe_r <= busy ? SER_OE : 8'h00;
      end else begin
        rdp_r <= st68 ? strobe : ~(strobe & rd_op);
        wrp_r <= st68 ? (rd_op | ~busy) : ~(strobe & ~rd_op);
        dout_r <= cmd_r[7:0];
        doe_r <= (busy && !rd_op) ? PAR_OE : 8'h00;
      end
    end
  end

  assign link.chip_reset_n = ctrl_r[CTRL_RST];
  assign link.interface_select = if_r;
  assign link.bus_style_select = sty_r;
  assign link.unit_select_n = cs_n_r;
  assign link.data_command_select = dc_r;
  assign link.rd_strobe_pin = rdp_r;
  assign link.wr_strobe_pin = wrp_r;
  assign link.host_dout = dout_r;
  assign link.host_doe = doe_r;
endmodule : lcdhi_host

// File: lcdhi_properties.sv
// Concurrent checks on the pins between the two LCD host port ends
`timescale 1ns/1ps
module lcdhi_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic interface_select,
  input wire logic bus_style_select,
  input wire logic unit_select_n,
  input wire logic rd_strobe_pin,
  input wire logic wr_strobe_pin,
  input wire logic [7:0] host_doe,
  input wire logic [7:0] dev_doe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus ownership and strobes
  // Device sees pins through synchronisers, so each device-drive check allows a few cycles of lag
  cs_float_a: assert property (unit_select_n[*5] |-> dev_doe == 8'h00)
    else $error("device drives while deselected");
  serial_float_a: assert property ((!interface_select)[*5] |-> dev_doe == 8'h00)
    else $error("device drives in serial mode");
  rd80_drive_a: assert property ((interface_select && !bus_style_select && !unit_select_n
    && !rd_strobe_pin)[*6] |-> dev_doe == 8'hff) else $error("no drive during 80 read");
  rd80_quiet_a: assert property ((!bus_style_select && rd_strobe_pin)[*5] |-> dev_doe == 8'h00)
    else $error("drive outside 80 read strobe");
  rd68_drive_a: assert property ((interface_select && bus_style_select && !unit_select_n
    && rd_strobe_pin && wr_strobe_pin)[*6] |-> dev_doe == 8'hff) else $error("no drive during 68 read");
  rd68_quiet_a: assert property ((bus_style_select && !(rd_strobe_pin && wr_strobe_pin))[*5]
    |-> dev_doe == 8'h00) else $error("drive outside 68 read");
  bus_contention_a: assert property ((host_doe & dev_doe) == 8'h00)
    else $error("both ends drive the bus");
  serial_pins_a: assert property (!interface_select && host_doe != 8'h00 |-> host_doe == 8'hc0)
    else $error("host drives wrong pins in serial");
  serial_strobe_a: assert property (!interface_select |-> rd_strobe_pin && wr_strobe_pin)
    else $error("strobes move in serial mode");
  rd_width_a: assert property (interface_select && !bus_style_select && $fell(rd_strobe_pin)
    |-> (!rd_strobe_pin)[*8] ##1 rd_strobe_pin) else $error("read strobe width wrong");
  wr_width_a: assert property (interface_select && !bus_style_select && $fell(wr_strobe_pin)
    |-> !unit_select_n throughout ((!wr_strobe_pin)[*8] ##1 wr_strobe_pin)) else $error("write strobe wrong");
  // ==========================================================
  // Main scenarios reached
  cov_rd80_c: cover property (interface_select && !bus_style_select && !rd_strobe_pin);
  cov_rd68_c: cover property (interface_select && bus_style_select && rd_strobe_pin && wr_strobe_pin);
  cov_ser_c: cover property (!interface_select && !unit_select_n);
endmodule : lcdhi_properties

// File: lcdhi_tb.sv
// Self-checking bench joining the host and device ends of the LCD host port
`timescale 1ns/1ps
module lcdhi_tb;
  import lcdhi_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, rx_ready;
  logic [7:0] paddr, rd_status, rd_display, rx_data;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, rx_valid, rx_is_data, rx_overflow, serial_mode, style68, rd_taken;
  logic [1:0] rx_count;
  int n_fail, checked, n_rd;
  lcdhi_if i_lcdhi_if ();
  lcdhi_host i_lcdhi_host (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_lcdhi_if));
  lcdhi_device i_lcdhi_device (.pclk(pclk), .presetn(presetn), .ce(ce), .link(i_lcdhi_if),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_is_data(rx_is_data),
    .rx_overflow(rx_overflow), .rd_status(rd_status), .rd_display(rd_display), .rd_taken(rd_taken),
    .serial_mode(serial_mode), .style68(style68), .rx_count(rx_count));
  lcdhi_properties i_lcdhi_properties (.pclk(pclk), .presetn(presetn),
    .interface_select(i_lcdhi_if.interface_select), .bus_style_select(i_lcdhi_if.bus_style_select),
    .unit_select_n(i_lcdhi_if.unit_select_n), .rd_strobe_pin(i_lcdhi_if.rd_strobe_pin),
    .wr_strobe_pin(i_lcdhi_if.wr_strobe_pin), .host_doe(i_lcdhi_if.host_doe), .dev_doe(i_lcdhi_if.dev_doe));
  // ==========================================================
  // Clock, verdict, watchdog
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic finish_test;
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
  // Completed parallel reads seen by the device, one pulse each
  always @(posedge pclk) begin
    if (rd_taken === 1'b1) n_rd++;
  end
  // ==========================================================
  // Compare and bus tasks
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask : chk_b
  // A fresh edge first, so back-to-back calls never assign psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic set_ctrl(input logic [31:0] v);
    logic [31:0] q;
    logic e;
    apb(1'b1, REG_CTRL, v, q, e);
    repeat (12) @(posedge pclk);
  endtask : set_ctrl
  // Busy must be polled: a command issued while busy is dropped
  task automatic send(input logic [7:0] b, input logic dc, input logic rd);
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b1, REG_CMD, {22'h0, rd, dc, b}, q, e);
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0000_0000, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    chk_b(q[0], 1'b0);
  endtask : send
  task automatic wait_rx(input logic [1:0] cnt);
    int n;
    n = 0;
    while (rx_count !== cnt && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk_w({30'h0, rx_count}, {30'h0, cnt});
  endtask : wait_rx
  task automatic pop(input logic [7:0] b, input logic dc);
    @(posedge pclk);
    chk_b(rx_valid, 1'b1);
    chk_w({24'h0, rx_data}, {24'h0, b});
    chk_b(rx_is_data, dc);
    rx_ready <= 1'b1;
    @(posedge pclk);
    rx_ready <= 1'b0;
  endtask : pop
  task automatic chk_rx(input logic [7:0] b);
    logic [31:0] q;
    logic e;
    apb(1'b0, REG_RX, 32'h0000_0000, q, e);
    chk_w(q, {24'h0, b});
  endtask : chk_rx
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    apb(1'b0, REG_CTRL, 32'h0000_0000, q, e);
    chk_w(q, 32'h0000_0005);
    apb(1'b0, 8'h10, 32'h0000_0000, q, e);
    chk_b(e, 1'b1);
    chk_b(rx_valid, 1'b0);
  endtask : t_reset
  task automatic t_par(input logic [31:0] ctrl);
    int r0;
    r0 = n_rd;
    set_ctrl(ctrl);
    chk_b(style68, ctrl[1]);
    chk_b(serial_mode, 1'b0);
    send(8'ha5, 1'b1, 1'b0);
    send(8'h3c, 1'b0, 1'b0);
    wait_rx(2'h2);
    pop(8'ha5, 1'b1);
    pop(8'h3c, 1'b0);
    send(8'h00, 1'b0, 1'b1);
    chk_rx(8'h96);
    send(8'h00, 1'b1, 1'b1);
    chk_rx(8'h69);
    chk_w(32'(n_rd - r0), 32'h0000_0002);
    wait_rx(2'h0);
  endtask : t_par
  task automatic t_serial;
    set_ctrl(32'h0000_0004);
    chk_b(serial_mode, 1'b1);
    send(8'h1e, 1'b1, 1'b0);
    send(8'h81, 1'b0, 1'b0);
    wait_rx(2'h2);
    pop(8'h1e, 1'b1);
    pop(8'h81, 1'b0);
    rd_status <= 8'h5a;
    send(8'h00, 1'b0, 1'b1);
    chk_rx(8'h69);
    rd_status <= 8'h96;
  endtask : t_serial
  // Receiver stalls: third byte finds the two-entry buffer full and is dropped
  task automatic t_overflow;
    set_ctrl(32'h0000_0005);
    send(8'h11, 1'b1, 1'b0);
    send(8'h22, 1'b1, 1'b0);
    send(8'h33, 1'b1, 1'b0);
    wait_rx(2'h2);
    chk_b(rx_overflow, 1'b1);
    pop(8'h11, 1'b1);
    pop(8'h22, 1'b1);
    wait_rx(2'h0);
    send(8'h44, 1'b0, 1'b0);
    wait_rx(2'h1);
    set_ctrl(32'h0000_0001);
    set_ctrl(32'h0000_0005);
    chk_b(rx_overflow, 1'b0);
    chk_b(rx_valid, 1'b0);
  endtask : t_overflow
  initial begin
    n_fail = 0;
    checked = 0;
    n_rd = 0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rx_ready = 1'b0;
    rd_status = 8'h96;
    rd_display = 8'h69;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_par(32'h0000_0005);
    t_par(32'h0000_0007);
    t_serial;
    t_overflow;
    finish_test;
  end
endmodule : lcdhi_tb
